// ==== design/timer_cc_pkg.sv ====
// Constants, register map and types of the modulo and capture/compare timer block
package timer_cc_pkg;

  // Register byte addresses on APB
  localparam logic [7:0] MOD_HIGH_ADDR = 8'h00;
  localparam logic [7:0] MOD_LOW_ADDR = 8'h04;
  localparam logic [7:0] SC0_ADDR = 8'h08;
  localparam logic [7:0] SC1_ADDR = 8'h0C;
  localparam logic [7:0] VAL0_HIGH_ADDR = 8'h10;
  localparam logic [7:0] VAL0_LOW_ADDR = 8'h14;
  localparam logic [7:0] VAL1_HIGH_ADDR = 8'h18;
  localparam logic [7:0] VAL1_LOW_ADDR = 8'h1C;
  localparam logic [7:0] TSC_ADDR = 8'h20;

  // Timer and channel status/control field positions
  localparam int OVF_FLAG_BIT = 7;
  localparam int OVF_IE_BIT = 6;
  localparam int STOP_BIT = 5;
  localparam int CRST_BIT = 4;
  localparam int CH_FLAG_BIT = 7;

  // Reset values
  localparam logic [15:0] MODULO_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic STOP_RESET = 1'h1;

  // Edge/level codes; capture uses 01 rise, 10 fall, 11 any
  localparam logic [1:0] ELS_NONE = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;

  // Channel status/control byte, bit 7 down to bit 0
  typedef struct packed {
    logic flag;
    logic ie;
    logic ms_b;
    logic ms_a;
    logic [1:0] els;
    logic tov;
    logic max;
  } chan_ctrl_t;

  typedef enum logic [1:0] {MODE_PRESET, MODE_CAPTURE, MODE_COMPARE, MODE_BUFFERED} chan_mode_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_MOD_H, SEL_MOD_L, SEL_SC0, SEL_SC1,
    SEL_V0_H, SEL_V0_L, SEL_V1_H, SEL_V1_L, SEL_TSC
  } reg_sel_t;

endpackage : timer_cc_pkg

// ==== design/timer_modulo_capture_compare.sv ====
// Modulo counter with capture/compare channel 0 and compare-only channel 1 behind an APB slave
module timer_modulo_capture_compare
  import timer_cc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Channel 0 pin
  input wire logic channel0_pin_i,
  output logic channel0_pin_o,
  output logic channel0_pin_oe_o,
  // Interrupt requests
  output logic overflow_irq_o,
  output logic [1:0] channel_irq_o
);

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  function automatic chan_mode_t decode_mode(input chan_ctrl_t c);
    if (c.els == ELS_NONE) begin
      return MODE_PRESET;
    end else if (c.ms_b) begin
      return MODE_BUFFERED;
    end else if (c.ms_a) begin
      return MODE_COMPARE;
    end
    return MODE_CAPTURE;
  endfunction : decode_mode

  // Compare also runs with the pin released when mode A is one
  function automatic logic compare_on(input chan_ctrl_t c);
    return (decode_mode(c) == MODE_COMPARE) || (decode_mode(c) == MODE_BUFFERED) ||
           (decode_mode(c) == MODE_PRESET && c.ms_a);
  endfunction : compare_on

  logic [15:0] counter;
  logic [15:0] modulo;
  logic [15:0] value [2];
  chan_ctrl_t ctrl [2];
  chan_ctrl_t eff [2];
  chan_mode_t mode [2];
  logic stop, ovf_flag, ovf_ie, ovf_armed, mod_lock;
  logic [1:0] armed, cap_lock, cmp_lock, match, evt;
  logic active_sel, pending, max_active, pin_level;
  logic pin_s1, pin_s2, pin_s3;
  logic wr, rd, tick, wrap, ovf_event, counter_clear, cap_edge;
  logic [15:0] cmp_value [2];
  logic [7:0] next_rdata;
  reg_sel_t sel;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;
  assign pready_o = penable_i;
  assign pslverr_o = psel_i && penable_i && (sel == SEL_NONE);

  always_comb begin
    if (paddr_i == ADDR_W'(MOD_HIGH_ADDR)) begin
      sel = SEL_MOD_H;
    end else if (paddr_i == ADDR_W'(MOD_LOW_ADDR)) begin
      sel = SEL_MOD_L;
    end else if (paddr_i == ADDR_W'(SC0_ADDR)) begin
      sel = SEL_SC0;
    end else if (paddr_i == ADDR_W'(SC1_ADDR)) begin
      sel = SEL_SC1;
    end else if (paddr_i == ADDR_W'(VAL0_HIGH_ADDR)) begin
      sel = SEL_V0_H;
    end else if (paddr_i == ADDR_W'(VAL0_LOW_ADDR)) begin
      sel = SEL_V0_L;
    end else if (paddr_i == ADDR_W'(VAL1_HIGH_ADDR)) begin
      sel = SEL_V1_H;
    end else if (paddr_i == ADDR_W'(VAL1_LOW_ADDR)) begin
      sel = SEL_V1_L;
    end else if (paddr_i == ADDR_W'(TSC_ADDR)) begin
      sel = SEL_TSC;
    end else begin
      sel = SEL_NONE;
    end
  end

  // Channel 1 control reads and acts as zero while the channel 0 mode B bit is one
  always_comb begin
    eff[0] = ctrl[0];
    eff[1] = ctrl[0].ms_b ? '0 : ctrl[1];
    mode[0] = decode_mode(eff[0]);
    mode[1] = decode_mode(eff[1]);
  end

  always_comb begin
    next_rdata = 8'h00;
    case (sel)
      SEL_MOD_H: next_rdata = modulo[15:8];
      SEL_MOD_L: next_rdata = modulo[7:0];
      SEL_SC0: next_rdata = eff[0];
      SEL_SC1: next_rdata = eff[1];
      SEL_V0_H: next_rdata = value[0][15:8];
      SEL_V0_L: next_rdata = value[0][7:0];
      SEL_V1_H: next_rdata = value[1][15:8];
      SEL_V1_L: next_rdata = value[1][7:0];
      SEL_TSC: next_rdata = {ovf_flag, ovf_ie, stop, 5'h00};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data settles in the setup cycle so the access cycle can end at once
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= {24'h00_0000, next_rdata};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter and modulo

  assign counter_clear = wr && sel == SEL_TSC && pwdata_i[CRST_BIT];
  assign tick = !stop && !counter_clear;
  assign wrap = tick && (counter == modulo);
  assign ovf_event = wrap && !mod_lock;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      counter <= COUNT_ZERO;
    end else if (counter_clear) begin
      counter <= COUNT_ZERO;
    end else if (wrap) begin
      counter <= COUNT_ZERO;
    end else if (tick) begin
      counter <= counter + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      modulo <= MODULO_RESET;
      mod_lock <= 1'b0;
    end else if (wr && sel == SEL_MOD_H) begin
      modulo[15:8] <= pwdata_i[7:0];
      mod_lock <= 1'b1;
    end else if (wr && sel == SEL_MOD_L) begin
      modulo[7:0] <= pwdata_i[7:0];
      mod_lock <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stop <= STOP_RESET;
      ovf_ie <= 1'b0;
      ovf_flag <= 1'b0;
      ovf_armed <= 1'b0;
    end else begin
      if (wr && sel == SEL_TSC) begin
        stop <= pwdata_i[STOP_BIT];
        ovf_ie <= pwdata_i[OVF_IE_BIT];
      end
      if (ovf_event) begin
        ovf_flag <= 1'b1;
        ovf_armed <= 1'b0;
      end else if (wr && sel == SEL_TSC && !pwdata_i[OVF_FLAG_BIT] && ovf_armed) begin
        ovf_flag <= 1'b0;
        ovf_armed <= 1'b0;
      end else if (rd && sel == SEL_TSC && prdata_o[OVF_FLAG_BIT]) begin
        // Arm only on the value software actually saw in the setup cycle
        ovf_armed <= 1'b1;
      end
    end
  end

  assign overflow_irq_o = ovf_ie && ovf_flag && !mod_lock;

  //////////////////////////////////////////////////////////////////////////////
  // Channel events

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= channel0_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_comb begin
    cap_edge = 1'b0;
    case (eff[0].els)
      ELS_TOGGLE: cap_edge = pin_s2 && !pin_s3;
      ELS_CLEAR: cap_edge = !pin_s2 && pin_s3;
      ELS_SET: cap_edge = pin_s2 != pin_s3;
      default: cap_edge = 1'b0;
    endcase
  end

  // Buffered mode compares against whichever value register is active
  assign cmp_value[0] = (mode[0] == MODE_BUFFERED) ? value[active_sel] : value[0];
  assign cmp_value[1] = value[1];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      match[i] = tick && compare_on(eff[i]) && !cmp_lock[i] &&
                 (counter == cmp_value[i]);
    end
    if (mode[0] == MODE_BUFFERED && cmp_lock[1]) begin
      match[0] = 1'b0;
    end
    // Channel 1 has no pin, so it never captures
    evt[0] = match[0] || (mode[0] == MODE_CAPTURE && !cap_lock[0] && cap_edge);
    evt[1] = match[1];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl[0] <= '0;
      ctrl[1] <= '0;
      armed <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr && sel == (i == 0 ? SEL_SC0 : SEL_SC1) && !(i == 1 && ctrl[0].ms_b)) begin
          ctrl[i][6:0] <= pwdata_i[6:0];
        end
        // A new event beats a clear in the same cycle
        if (evt[i]) begin
          ctrl[i].flag <= 1'b1;
          armed[i] <= 1'b0;
        end else if (wr && sel == (i == 0 ? SEL_SC0 : SEL_SC1) && armed[i] &&
                     !pwdata_i[CH_FLAG_BIT]) begin
          ctrl[i].flag <= 1'b0;
          armed[i] <= 1'b0;
        end else if (rd && sel == (i == 0 ? SEL_SC0 : SEL_SC1) && prdata_o[CH_FLAG_BIT]) begin
          armed[i] <= 1'b1;
        end
      end
    end
  end

  assign channel_irq_o[0] = eff[0].ie && eff[0].flag;
  assign channel_irq_o[1] = eff[1].ie && eff[1].flag;

  //////////////////////////////////////////////////////////////////////////////
  // Value registers; left unreset on purpose

  always_ff @(posedge clk_i) begin
    if (evt[0] && mode[0] == MODE_CAPTURE) begin
      value[0] <= counter;
    end else if (wr && sel == SEL_V0_H) begin
      value[0][15:8] <= pwdata_i[7:0];
    end else if (wr && sel == SEL_V0_L) begin
      value[0][7:0] <= pwdata_i[7:0];
    end
    if (wr && sel == SEL_V1_H) begin
      value[1][15:8] <= pwdata_i[7:0];
    end else if (wr && sel == SEL_V1_L) begin
      value[1][7:0] <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cap_lock <= 2'b00;
      cmp_lock <= 2'b00;
    end else begin
      if (rd && sel == SEL_V0_H && mode[0] == MODE_CAPTURE) begin
        cap_lock[0] <= 1'b1;
      end else if (rd && sel == SEL_V0_L) begin
        cap_lock[0] <= 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
        if (wr && sel == (i == 0 ? SEL_V0_H : SEL_V1_H) &&
            (compare_on(eff[i]) || mode[0] == MODE_BUFFERED)) begin
          cmp_lock[i] <= 1'b1;
        end else if (wr && sel == (i == 0 ? SEL_V0_L : SEL_V1_L)) begin
          cmp_lock[i] <= 1'b0;
        end
      end
    end
  end

  // The idle value register takes over at the next overflow once rewritten
  always_ff @(posedge clk_i) begin
    if (reset_i || mode[0] != MODE_BUFFERED) begin
      active_sel <= 1'b0;
      pending <= 1'b0;
    end else if (wrap && pending) begin
      active_sel <= !active_sel;
      pending <= 1'b0;
    end else if (wr && sel == (active_sel ? SEL_V0_L : SEL_V1_L)) begin
      pending <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin output

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      max_active <= 1'b0;
      pin_level <= 1'b1;
    end else begin
      if (wrap) begin
        max_active <= ctrl[0].max;
      end
      if (mode[0] == MODE_PRESET) begin
        pin_level <= !ctrl[0].ms_a;
      end else if (mode[0] != MODE_CAPTURE) begin
        if (wrap && ctrl[0].tov) begin
          // Overflow first; clear-mode with max duty lands high
          pin_level <= (ctrl[0].max && ctrl[0].els == ELS_CLEAR) ? 1'b1 : !pin_level;
        end else if (match[0]) begin
          case (ctrl[0].els)
            ELS_TOGGLE: pin_level <= !pin_level;
            ELS_CLEAR: pin_level <= (max_active && ctrl[0].tov);
            ELS_SET: pin_level <= 1'b1;
            default: pin_level <= pin_level;
          endcase
        end
      end
    end
  end

  assign channel0_pin_o = pin_level;
  assign channel0_pin_oe_o = mode[0] == MODE_COMPARE || mode[0] == MODE_BUFFERED;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_max_start;
    wrap && ctrl[0].max && ctrl[0].tov && ctrl[0].els == ELS_CLEAR &&
    (mode[0] == MODE_COMPARE || mode[0] == MODE_BUFFERED);
  endsequence

  sequence s_rise_capture;
    mode[0] == MODE_CAPTURE && eff[0].els == ELS_TOGGLE && !cap_lock[0] &&
    pin_s2 && !pin_s3;
  endsequence

  a_wrap_restart: assert property (@(posedge clk_i) disable iff (reset_i)
    wrap && !counter_clear |=> counter == COUNT_ZERO && (ovf_flag || $past(mod_lock)))
    else $error("counter did not restart after modulo match");
  a_modulo_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    mod_lock |=> !$rose(ovf_flag))
    else $error("overflow flag set while modulo high pending");
  a_modulo_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(reset_i) |-> modulo == MODULO_RESET)
    else $error("modulo not all ones after reset");
  a_match_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    match[0] |=> ctrl[0].flag ##1 ctrl[0].flag || $past(wr))
    else $error("match did not set channel flag");
  a_flag_one_write: assert property (@(posedge clk_i) disable iff (reset_i)
    wr && sel == SEL_SC0 && pwdata_i[CH_FLAG_BIT] && ctrl[0].flag |=> ctrl[0].flag)
    else $error("writing one cleared channel flag");
  a_irq_request: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(ctrl[0].flag) && ctrl[0].ie |-> channel_irq_o[0])
    else $error("channel irq missing");
  a_preset_level: assert property (@(posedge clk_i) disable iff (reset_i)
    mode[0] == MODE_PRESET ##1 mode[0] == MODE_PRESET |-> !channel0_pin_oe_o &&
    channel0_pin_o == !$past(ctrl[0].ms_a))
    else $error("preset level or release wrong");
  a_ovf_priority: assert property (@(posedge clk_i) disable iff (reset_i)
    wrap && ctrl[0].tov && match[0] && ctrl[0].els == ELS_SET && mode[0] == MODE_COMPARE
    && !ctrl[0].max |=> channel0_pin_o != $past(channel0_pin_o))
    else $error("overflow toggle lost to compare");
  a_max_high: assert property (@(posedge clk_i) disable iff (reset_i)
    s_max_start |=> channel0_pin_o)
    else $error("max duty did not force high");
  a_rise_capture: assert property (@(posedge clk_i) disable iff (reset_i)
    s_rise_capture |=> ctrl[0].flag && value[0] == $past(counter))
    else $error("rising edge not captured");
  a_capture_lock: assert property (@(posedge clk_i) disable iff (reset_i)
    cap_lock[0] && !wr |=> value[0] == $past(value[0]))
    else $error("capture during high byte lock");

endmodule : timer_modulo_capture_compare

// ==== verif/timer_pin_model.sv ====
// Channel 0 pad partner: resolves the shared pin from the block and an outside source
module timer_pin_model (
  // Block side
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  // Outside source
  input wire logic ext_level_i,
  // Resolved pad level
  output logic pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Block drive wins; the outside source only shows while the block lets go
  assign pad_o = pin_oe_i ? pin_o_i : ext_level_i;
endmodule : timer_pin_model

// ==== verif/timer_modulo_capture_compare_tb.sv ====
// Self-checking bench for the modulo and capture/compare timer block
module timer_modulo_capture_compare_tb;
  import timer_cc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic channel0_pin_i, channel0_pin_o, channel0_pin_oe_o, overflow_irq_o, ext_level;
  logic [1:0] channel_irq_o;
  logic [7:0] rd, c;
  logic err, a, b;
  int fail_count, compares, i;
  logic [7:0] tcfg [4] = '{8'h54, 8'h56, 8'h56, 8'h5E};
  logic [15:0] tval [4] = '{16'h0008, 16'h00FF, 16'h0010, 16'h0010};

  timer_modulo_capture_compare i_timer_modulo_capture_compare (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .channel0_pin_i(channel0_pin_i),
    .channel0_pin_o(channel0_pin_o), .channel0_pin_oe_o(channel0_pin_oe_o),
    .overflow_irq_o(overflow_irq_o), .channel_irq_o(channel_irq_o));
  timer_pin_model i_timer_pin_model (.pin_o_i(channel0_pin_o),
    .pin_oe_i(channel0_pin_oe_o), .ext_level_i(ext_level), .pad_o(channel0_pin_i));

  ////////////////////////////////////////////////////////////
  task test_done;
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task chk_bit(input logic s, input logic e);
    chk({7'h00, s}, {7'h00, e});
  endtask : chk_bit

  // Entered right after a rising edge; leaves one idle cycle so strobes never double-assign
  task apb(input logic w, input logic [7:0] adr, input logic [7:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= adr;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t bus answer missing", $time);
      test_done();
    end
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task wr(input logic [7:0] adr, input logic [7:0] d);
    apb(1'b1, adr, d);
  endtask : wr

  task rc(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] exp);
    apb(1'b0, adr, 8'h00);
    chk(rd & m, exp);
  endtask : rc

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task pin(input int n, output logic v);
    repeat (n) @(negedge clk_i);
    v = channel0_pin_o;
    @(posedge clk_i);
  endtask : pin

  // Counter stopped and cleared around every mode change
  task cfg0(input logic [7:0] v);
    wr(TSC_ADDR, 8'h30);
    wr(SC0_ADDR, v);
    wr(TSC_ADDR, 8'h10);
  endtask : cfg0

  task val0(input logic [15:0] v);
    wr(VAL0_HIGH_ADDR, v[15:8]);
    wr(VAL0_LOW_ADDR, v[7:0]);
  endtask : val0

  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    $display("[ERR] %0t run limit reached", $time);
    test_done();
  end

  initial begin
    fail_count = 0;
    compares = 0;
    reset_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    ext_level = 1'b0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rc(MOD_HIGH_ADDR, 8'hFF, 8'hFF);
    rc(MOD_LOW_ADDR, 8'hFF, 8'hFF);
    rc(SC0_ADDR, 8'hFF, 8'h00);
    rc(SC1_ADDR, 8'hFF, 8'h00);
    rc(TSC_ADDR, 8'hE0, 8'h20);
    rc(8'h24, 8'hFF, 8'h00);
    chk_bit(err, 1'b1);
    // Modulo 16, overflow interrupt on
    wr(TSC_ADDR, 8'h30);
    wr(MOD_HIGH_ADDR, 8'h00);
    wr(MOD_LOW_ADDR, 8'h10);
    wr(TSC_ADDR, 8'h50);
    cyc(40);
    rc(TSC_ADDR, 8'h80, 8'h80);
    chk_bit(overflow_irq_o, 1'b1);
    wr(MOD_HIGH_ADDR, 8'h00);
    rc(TSC_ADDR, 8'h80, 8'h80);
    wr(TSC_ADDR, 8'h40);
    cyc(40);
    rc(TSC_ADDR, 8'h80, 8'h00);
    chk_bit(overflow_irq_o, 1'b0);
    wr(MOD_LOW_ADDR, 8'h10);
    cyc(40);
    rc(TSC_ADDR, 8'h80, 8'h80);
    wr(VAL1_HIGH_ADDR, 8'hAB);
    wr(VAL1_LOW_ADDR, 8'hCD);
    rc(VAL1_HIGH_ADDR, 8'hFF, 8'hAB);
    rc(VAL1_LOW_ADDR, 8'hFF, 8'hCD);
    val0(16'h0008);
    for (i = 0; i < 4; i++) begin
      cfg0({4'h5, i[1:0], 2'b00});
      cyc(40);
      rc(SC0_ADDR, 8'h80, 8'h80);
      chk_bit(channel_irq_o[0], 1'b1);
      chk_bit(channel0_pin_oe_o, i != 0);
      if (i >= 2) chk_bit(channel0_pin_o, i[0]);
      if (i == 0) chk_bit(channel0_pin_o, 1'b0);
    end
    // Toggle on match, on overflow, both at once, and overflow against set
    for (i = 0; i < 4; i++) begin
      val0(tval[i]);
      cfg0(tcfg[i]);
      pin(10, a);
      pin(17, b);
      chk_bit(b, ~a);
    end
    val0(16'h0108);
    cfg0(8'h54);
    apb(1'b0, SC0_ADDR, 8'h00);
    wr(SC0_ADDR, 8'h54);
    cyc(40);
    rc(SC0_ADDR, 8'h80, 8'h00);
    wr(VAL0_HIGH_ADDR, 8'h00);
    cyc(40);
    rc(SC0_ADDR, 8'h80, 8'h00);
    wr(VAL0_LOW_ADDR, 8'h08);
    cyc(40);
    rc(SC0_ADDR, 8'h80, 8'h80);
    wr(TSC_ADDR, 8'h30);
    wr(SC0_ADDR, 8'hD4);
    rc(SC0_ADDR, 8'h80, 8'h80);
    wr(SC0_ADDR, 8'h54);
    rc(SC0_ADDR, 8'h80, 8'h00);
    chk_bit(channel_irq_o[0], 1'b0);
    // Forced full duty, then zero duty by software choice
    cfg0(8'h1B);
    cyc(40);
    for (i = 0; i < 6; i++) begin
      if (i == 3) begin
        cfg0(8'h18);
        cyc(40);
      end
      pin(6, a);
      chk_bit(a, i < 3);
    end
    for (i = 1; i < 4; i++) begin
      c = {4'h0, i[1:0], 2'b00};
      cfg0(c);
      cyc(10);
      apb(1'b0, SC0_ADDR, 8'h00);
      wr(SC0_ADDR, c);
      ext_level <= 1'b1;
      cyc(8);
      rc(SC0_ADDR, 8'h80, {i[0], 7'h00});
      wr(SC0_ADDR, c);
      ext_level <= 1'b0;
      cyc(8);
      rc(SC0_ADDR, 8'h80, {i[1], 7'h00});
    end
    apb(1'b0, VAL0_LOW_ADDR, 8'h00);
    c = rd;
    apb(1'b0, VAL0_HIGH_ADDR, 8'h00);
    ext_level <= 1'b1;
    cyc(8);
    rc(VAL0_LOW_ADDR, 8'hFF, c);
    ext_level <= 1'b0;
    val0(16'h0008);
    cfg0(8'h2C);
    cyc(40);
    chk_bit(channel0_pin_o, 1'b1);
    chk_bit(channel0_pin_oe_o, 1'b1);
    wr(SC1_ADDR, 8'h50);
    rc(SC1_ADDR, 8'hFF, 8'h00);
    chk_bit(channel_irq_o[1], 1'b0);
    test_done();
  end
endmodule : timer_modulo_capture_compare_tb
